// ===== logic/pdc_ctrl.sv
// controller end: writes or reads back the chain over the three-wire link
`timescale 1ns/1ps
module pdc_ctrl
   import pdc_pkg::*;
#(
   parameter int N_DEV = 1
)(
   input  wire logic                   I_CLK,
   input  wire logic                   I_RST,
   input  wire logic                   I_START,
   input  wire logic                   I_READ,
   input  wire logic [17*N_DEV-1:0]    I_WORD,
   output logic                        O_BUSY,
   output logic                        O_DONE,
   output logic [17*N_DEV-1:0]         O_RDATA,
   pdc_link_if.ctrl                    LINK
);
   localparam int TOTAL = SR_BITS * N_DEV;
   localparam int BW    = $clog2(TOTAL + 1);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_LEAD = 3'h1,
      S_HIGH = 3'h2,
      S_LOW  = 3'h3,
      S_TAIL = 3'h4,
      S_GAP  = 3'h5
   } pdc_state_t;

   typedef struct packed {
      pdc_state_t       st;
      logic [TMR_W-1:0] tmr;
      logic [BW-1:0]    bits;
      logic [TOTAL-1:0] tx;
      logic [TOTAL-1:0] rx;
      logic [1:0]       dq_sync;
      logic             rd;
      logic             sclk;
      logic             sel;
      logic             done;
   } pdc_ctl_st_t;

   pdc_ctl_st_t q;
   pdc_ctl_st_t d;

   function automatic logic [TMR_W-1:0] ld(input int cyc);
      return TMR_W'(cyc - 1);
   endfunction : ld

   // ---------------------------------------------------------------
   // sequencer: clock is divided from I_CLK, bits leave MSB first
   // ---------------------------------------------------------------
   always_comb begin
      d         = q;
      d.done    = 1'b0;
      d.dq_sync = {q.dq_sync[0], LINK.dq_line};
      if (q.tmr != '0) begin
         d.tmr = q.tmr - 1'b1;
      end
      unique case (q.st)
         S_IDLE: begin
            if (I_START) begin
               d.st   = S_LEAD;
               d.sel  = 1'b1;
               d.tx   = I_WORD;
               d.rd   = I_READ;
               d.bits = '0;
               d.tmr  = ld(LEAD_CYC);
            end
         end
         S_LEAD, S_LOW: begin
            if (q.tmr == '0) begin
               // line stood a whole half period, so the sample is settled
               d.rx   = {q.rx[TOTAL-2:0], q.dq_sync[1]};
               d.st   = S_HIGH;
               d.sclk = 1'b1;
               d.tmr  = ld(HALF_CYC);
            end
         end
         S_HIGH: begin
            if (q.tmr == '0) begin
               d.sclk = 1'b0;
               if (q.bits == BW'(TOTAL - 1)) begin
                  d.st  = S_TAIL;
                  d.tmr = ld(TAIL_CYC);
               end else begin
                  d.st   = S_LOW;
                  d.bits = q.bits + 1'b1;
                  d.tx   = {q.tx[TOTAL-2:0], 1'b0};
                  d.tmr  = ld(HALF_CYC);
               end
            end
         end
         S_TAIL: begin
            if (q.tmr == '0) begin
               d.st  = S_GAP;
               d.sel = 1'b0;
               d.tmr = ld(RLT_CYC);
            end
         end
         S_GAP: begin
            if (q.tmr == '0) begin
               d.st   = S_IDLE;
               d.done = 1'b1;
            end
         end
         default: begin
            d.st   = S_IDLE;
            d.sel  = 1'b0;
            d.sclk = 1'b0;
         end
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         q <= '{st: S_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign LINK.sclk   = q.sclk;
   assign LINK.sel    = q.sel;
   assign LINK.dq_drv = q.tx[TOTAL-1];
   assign LINK.dq_oe  = q.sel && !q.rd;
   assign O_BUSY      = (q.st != S_IDLE);
   assign O_DONE      = q.done;
   assign O_RDATA     = q.rx;
endmodule : pdc_ctrl

// ===== logic/pdc_pkg.sv
// shared constants of the setting chain: register layout and serial timing
package pdc_pkg;
   // ---------------------------------------------------------------
   // setting register layout (index 16 is nearest the cascade output)
   // ---------------------------------------------------------------
   localparam int          SR_BITS      = 17;
   localparam int          POS_STACK    = 16;
   localparam int          POS_POT1_MSB = 15;
   localparam int          POS_POT1_LSB = 8;
   localparam int          POS_POT0_MSB = 7;
   localparam int          POS_POT0_LSB = 0;
   localparam logic [7:0]  WIPER_RESET  = 8'h80;
   localparam logic        STACK_RESET  = 1'h0;
   localparam logic [16:0] SR_RESET     = {STACK_RESET, WIPER_RESET, WIPER_RESET};

   // ---------------------------------------------------------------
   // serial timing, in ns, and derived counts of system clock cycles
   // ---------------------------------------------------------------
   localparam int SYS_PERIOD_NS  = 5;
   localparam int SCLK_PERIOD_NS = 286;   // 3.5 MHz ceiling, rounded up
   localparam int T_CC_NS        = 50;    // select high to first rising clock
   localparam int T_HLT_NS       = 50;    // last clock to select low
   localparam int T_RLT_NS       = 125;   // select inactive time

   function automatic int ceil_cycles(input int ns);
      int c;
      c = (ns + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ceil_cycles

   localparam int HALF_CYC = ceil_cycles((SCLK_PERIOD_NS + 1) / 2);
   localparam int CC_CYC   = ceil_cycles(T_CC_NS);
   localparam int HLT_CYC  = ceil_cycles(T_HLT_NS);
   localparam int RLT_CYC  = ceil_cycles(T_RLT_NS);
   localparam int LEAD_CYC = (CC_CYC > HALF_CYC) ? CC_CYC : HALF_CYC;
   localparam int TAIL_CYC = (HLT_CYC > HALF_CYC) ? HLT_CYC : HALF_CYC;
   localparam int TMR_W    = 8;
endpackage : pdc_pkg

// ===== logic/pdc_link_if.sv
// three-wire link between the controller and one device, with loop-back
`timescale 1ns/1ps
interface pdc_link_if;
   logic sclk;        // serial clock, made by the controller
   logic sel;         // select, high during a transaction
   logic dq_drv;      // controller data out
   logic dq_oe;       // controller drives the data line
   logic cascade_out; // device cascade output
   logic dq_line;     // resolved data line level

   // loop-back resistor: an undriven line follows the cascade output
   assign dq_line = dq_oe ? dq_drv : cascade_out;

   modport ctrl (output sclk, output sel, output dq_drv, output dq_oe, input dq_line);
   modport dev  (input sclk, input sel, input dq_line, output cascade_out);
endinterface : pdc_link_if

// ===== logic/pdc_dev.sv
// device end: 17-bit setting shift register, cascade output, wiper latches
`timescale 1ns/1ps
module pdc_dev
   import pdc_pkg::*;
(
   input  wire logic  I_CLK,
   input  wire logic  I_RST,
   pdc_link_if.dev    LINK,
   output logic [7:0] O_WIPER0,
   output logic [7:0] O_WIPER1,
   output logic       O_STACK_SEL
);
   // ---------------------------------------------------------------
   // link domain state (serial clock)
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0]         rst_sync;
      logic [SR_BITS-1:0] sr;
   } pdc_lnk_st_t;

   pdc_lnk_st_t lnk_q;
   pdc_lnk_st_t lnk_d;

   // shift only while selected; reset loads the register at once, its release is seen only on serial clock edges
   always_comb begin
      lnk_d          = lnk_q;
      lnk_d.rst_sync = {lnk_q.rst_sync[0], 1'b0};
      if (lnk_q.rst_sync[1]) begin
         lnk_d.sr = SR_RESET;
      end else if (LINK.sel) begin
         lnk_d.sr = {lnk_q.sr[SR_BITS-2:0], LINK.dq_line};
      end
   end

   // reset of the link domain is released by a two-stage synchroniser
   always_ff @(posedge LINK.sclk or posedge I_RST) begin
      if (I_RST) begin
         lnk_q.rst_sync <= 2'h3;
         lnk_q.sr       <= SR_RESET;
      end else begin
         lnk_q <= lnk_d;
      end
   end

   // last bit always on the pin, so reading does not disturb the chain, save in the first transaction after reset
   assign LINK.cascade_out = lnk_q.sr[SR_BITS-1];

   // ---------------------------------------------------------------
   // system domain state: select synchroniser and wiper latches
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sel_sync;
      logic [7:0] wiper0;
      logic [7:0] wiper1;
      logic       stack;
   } pdc_sys_st_t;

   pdc_sys_st_t sys_q;
   pdc_sys_st_t sys_d;

   // the register is quiet once select is low, so the word crosses as is
   always_comb begin
      sys_d          = sys_q;
      sys_d.sel_sync = {sys_q.sel_sync[1:0], LINK.sel};
      if (sys_q.sel_sync[2] && !sys_q.sel_sync[1]) begin
         sys_d.stack  = lnk_q.sr[POS_STACK];
         sys_d.wiper1 = lnk_q.sr[POS_POT1_MSB:POS_POT1_LSB];
         sys_d.wiper0 = lnk_q.sr[POS_POT0_MSB:POS_POT0_LSB];
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         sys_q.sel_sync <= 3'h0;
         sys_q.wiper0   <= WIPER_RESET;
         sys_q.wiper1   <= WIPER_RESET;
         sys_q.stack    <= STACK_RESET;
      end else begin
         sys_q <= sys_d;
      end
   end

   assign O_WIPER0    = sys_q.wiper0;
   assign O_WIPER1    = sys_q.wiper1;
   assign O_STACK_SEL = sys_q.stack;
endmodule : pdc_dev

// ===== verification/pdc_link_assertions.sv
// checker for the three-wire link between the controller and the device
`timescale 1ns/1ps
module pdc_link_assertions #(
   parameter int N_DEV = 1
)(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic sclk,
   input wire logic sel,
   input wire logic dq_drv,
   input wire logic dq_oe,
   input wire logic cascade_out
);
   // ---------------------------------------------------------------
   // frame bit counter
   // ---------------------------------------------------------------
   logic [7:0] rises_q;
   logic       sclk_q;

   // counts rising serial edges in a frame, cleared while deselected
   always_ff @(posedge I_CLK) begin
      sclk_q <= sclk;
      if (I_RST || !sel) begin
         rises_q <= 8'h00;
      end else if (sclk && !sclk_q) begin
         rises_q <= rises_q + 8'h01;
      end
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   sequence s_clk_high;
      sclk [*8];
   endsequence
   sequence s_clk_low;
      !sclk [*8];
   endsequence

   idle_clk_a: assert property (!sel |-> !sclk)
      else $error("serial clock moved while deselected");
   lead_time_a: assert property ($rose(sel) |-> s_clk_low)
      else $error("clock rose too soon after select");
   high_width_a: assert property ($rose(sclk) |-> s_clk_high)
      else $error("clock high pulse too short");
   cascade_move_a: assert property (sel && $changed(cascade_out) |-> $rose(sclk))
      else $error("cascade moved off a rising clock");
   idle_hold_a: assert property (!sel && !$past(sel) |-> $stable(cascade_out))
      else $error("cascade moved while deselected");
   frame_bits_a: assert property ($fell(sel) |-> rises_q == 17 * N_DEV)
      else $error("frame bit count wrong");
   tail_time_a: assert property ($fell(sel) |-> !$past(sclk, 8))
      else $error("select fell too soon after clock");
   gap_time_a: assert property ($fell(sel) |-> !sel [*8])
      else $error("select inactive time too short");
   setup_hold_a: assert property (sel && dq_oe && $rose(sclk) |-> dq_drv == $past(dq_drv, 6) ##1 $stable(dq_drv) [*2])
      else $error("data moved around rising clock");
   oe_steady_a: assert property (sel && sclk |-> $stable(dq_oe))
      else $error("data line drive changed at clock high");
endmodule : pdc_link_assertions

// ===== verification/test_pot_setting_daisy_chain.sv
// self-checking bench: controller and device joined over one link
`timescale 1ns/1ps
module test_pot_setting_daisy_chain
   import pdc_pkg::*;
;
   logic        clk;
   logic        rst;
   logic        start;
   logic        rd;
   logic [16:0] word;
   logic        busy;
   logic        done;
   logic [16:0] rdata;
   logic [7:0]  wiper0;
   logic [7:0]  wiper1;
   logic        stack;
   logic [16:0] cur;
   logic        known;
   int          err_total;
   int          samples_checked;
   // bit 17 selects read-back
   logic [17:0] ops [6] = '{18'h20000, 18'h1A53C, 18'h20000, 18'h000FF, 18'h0FF00, 18'h20000};

   pdc_link_if link ();
   pdc_ctrl #(.N_DEV(1)) u_pdc_ctrl (.I_CLK(clk), .I_RST(rst), .I_START(start), .I_READ(rd), .I_WORD(word),
      .O_BUSY(busy), .O_DONE(done), .O_RDATA(rdata), .LINK(link.ctrl));
   pdc_dev u_pdc_dev (.I_CLK(clk), .I_RST(rst), .LINK(link.dev), .O_WIPER0(wiper0), .O_WIPER1(wiper1),
      .O_STACK_SEL(stack));
   pdc_link_assertions #(.N_DEV(1)) chk (.I_CLK(clk), .I_RST(rst), .sclk(link.sclk), .sel(link.sel),
      .dq_drv(link.dq_drv), .dq_oe(link.dq_oe), .cascade_out(link.cascade_out));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   // one transaction; first one after reset is a dummy, contents unknown
   task automatic xfer(input logic read_mode, input logic [16:0] w);
      int n;
      start <= 1'b1;
      rd    <= read_mode;
      word  <= w;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      // sample a little after the edge so flop outputs have settled
      while (link.sel !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (known) check({16'h0000, link.cascade_out}, {16'h0000, cur[16]});
      check({16'h0000, busy}, 17'h00001);
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      check({16'h0000, done}, 17'h00001);
      check({16'h0000, busy}, 17'h00000);
      if (read_mode) begin
         if (known) check(rdata, cur);
      end else begin
         cur = w;
         known = 1'b1;
      end
      repeat (2) @(posedge clk);
      if (known) check({stack, wiper1, wiper0}, cur);
   endtask : xfer

   // free-running system clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // cuts a hang short
   initial begin
      #100000;
      err_total++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      start = 1'b0;
      rd = 1'b0;
      word = 17'h00000;
      err_total = 0;
      samples_checked = 0;
      known = 1'b0;
      cur = SR_RESET;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({stack, wiper1, wiper0}, SR_RESET);
      foreach (ops[i]) xfer(ops[i][17], ops[i][16:0]);
      give_verdict();
   end
endmodule : test_pot_setting_daisy_chain
